// ==== lpag_pkg.sv ====
package lpag_pkg;
    localparam int SMP_W = 12;
    localparam int DAT_W = 16;
    localparam int ADR_W = 8;
    localparam int BUS_AW = 8;
    localparam int NUM_TBL = 4;
    localparam int OFF_HI = 15;
    localparam int OFF_LO = 10;
    localparam int ITP_HI = 9;
    localparam int ITP_LO = 8;
    localparam int PW_HI = 7;
    localparam int PW_LO = 6;
    localparam int TL_HI = 5;
    localparam int TL_LO = 3;
    localparam int BS_HI = 2;
    localparam int BS_LO = 0;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam int BASE_SHIFT = 5;
    localparam logic [2:0] SHIFT_TOP = 3'h7;
    localparam logic [1:0] FRAC_MAX = 2'h3;
    localparam logic [2:0] LEN_MIN_CODE = 3'h1;
    localparam logic [2:0] LEN_MAX_CODE = 3'h6;
    localparam logic [7:0] LEN_STEP = 8'h20;
    localparam logic [1:0] PW_X2 = 2'h2;
    localparam logic [1:0] PW_X4 = 2'h3;
    localparam logic [7:0] A_CFG0 = 8'h00;
    localparam logic [7:0] A_CFG1 = 8'h04;
    localparam logic [7:0] A_CFG2 = 8'h08;
    localparam logic [7:0] A_CFG3 = 8'h0c;
    localparam logic [7:0] A_CTRL = 8'h10;
    localparam logic [7:0] A_PWR = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_RES = 8'h1c;
    localparam logic [7:0] A_ADDR = 8'h20;
    localparam int IDX_LO = 2;
    localparam int C_STREAM = 0;
    localparam int C_START = 1;
    localparam int C_TSEL = 2;
    localparam int C_SRC = 4;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CALC = 3'b001,
        ST_FETCH1 = 3'b010,
        ST_WAIT1 = 3'b011,
        ST_FETCH2 = 3'b100,
        ST_WAIT2 = 3'b101
    } lpag_state_e;
endpackage

// ==== lpag_ptr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lpag_ptr_if;
    logic [15:0] cfg;
    logic [11:0] sample;
    logic [7:0] addr;
    logic [7:0] index;
    logic [7:0] len;
    logic [2:0] frac;
    logic at_end;
    modport calc(input cfg, sample, output addr, index, len, frac, at_end);
    modport user(output cfg, sample, input addr, index, len, frac, at_end);
endinterface
`default_nettype wire

// ==== lpag_ptr_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpag_ptr_calc (
    lpag_ptr_if.calc p // Pointer request and result.
);
    logic signed [5:0] off;
    logic [1:0] pw;
    logic [1:0] itp;
    logic [1:0] pw_sh;
    logic [2:0] sh;
    logic [11:0] raw;
    logic signed [16:0] off_s;
    logic signed [16:0] sum;
    logic signed [16:0] scaled;
    logic signed [13:0] ipart;

    // Unused length codes fall back to the smallest table.
    function automatic logic [7:0] tbl_len(input logic [2:0] code);
        if (code < lpag_pkg::LEN_MIN_CODE || code > lpag_pkg::LEN_MAX_CODE)
            return lpag_pkg::LEN_STEP;
        return 8'(code * lpag_pkg::LEN_STEP);
    endfunction

    always_comb begin
        off = $signed(p.cfg[lpag_pkg::OFF_HI:lpag_pkg::OFF_LO]);
        itp = p.cfg[lpag_pkg::ITP_HI:lpag_pkg::ITP_LO];
        pw = p.cfg[lpag_pkg::PW_HI:lpag_pkg::PW_LO];
        p.len = tbl_len(p.cfg[lpag_pkg::TL_HI:lpag_pkg::TL_LO]);
        sh = 3'(lpag_pkg::SHIFT_TOP - {1'b0, pw} - {1'b0, itp});
        raw = p.sample >> sh;
        pw_sh = (pw == lpag_pkg::PW_X4) ? 2'h2 :
                (pw == lpag_pkg::PW_X2) ? 2'h1 : 2'h0;
        off_s = 17'(off) <<< pw_sh;
        sum = $signed({5'h00, raw}) + (off_s <<< itp);
        // Every code is brought to three fraction bits to share one path.
        scaled = sum <<< (lpag_pkg::FRAC_MAX - itp);
        ipart = 14'(scaled >>> lpag_pkg::FRAC_MAX);
        p.index = 8'h00;
        p.frac = 3'h0;
        p.at_end = 1'b0;
        if (sum < 0) begin
            p.index = 8'h00;
        end else if (ipart >= $signed({6'h00, p.len - 8'h01})) begin
            p.index = p.len - 8'h01;
            p.at_end = 1'b1;
        end else begin
            p.index = ipart[7:0];
            p.frac = scaled[2:0];
        end
        // Base plus index wraps modulo the word space; equal codes alias.
        p.addr = 8'((8'(p.cfg[lpag_pkg::BS_HI:lpag_pkg::BS_LO])
                 << lpag_pkg::BASE_SHIFT) + p.index);
    end
endmodule
`default_nettype wire

// ==== lpag_interp.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpag_interp (
    input wire logic signed [15:0] first_val, // Entry at lower address.
    input wire logic signed [15:0] second_val, // Entry at next address.
    input wire logic [2:0] frac, // Fraction in eighths.
    output logic signed [15:0] result // Blended value.
);
    logic signed [16:0] diff;
    logic signed [20:0] prod;

    // Entries kept to 13 signed bits cannot overflow the sum.
    always_comb begin
        diff = 17'(second_val) - 17'(first_val);
        prod = 21'(diff) * 21'($signed({1'b0, frac}));
        result = 16'(17'(first_val) + 17'(prod >>> lpag_pkg::FRAC_MAX));
    end
endmodule
`default_nettype wire

// ==== lpag_top.sv ====
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Config word packs offset, interp, width, length, base.
// - Four tables, each with own config word.
// - Config words writable only in streaming mode.
// - Source is latest ADC or power parameter.
// - Shift sample right by seven minus codes.
// - Width codes give 5 to 8 integer bits.
// - Offset scaled by two or four for wide pointers.
// - Offset is six-bit two's complement.
// - Scaled offset added before limiting.
// - Clamp negative to zero, overrun to last.
// - Pointer wider than table is accepted.
// - Length codes 1-6 give 32 to 192 entries.
// - Interp code adds zero to three fraction bits.
// - Code zero returns the addressed word directly.
// - Address is base times 32 plus pointer.
// - Otherwise blend two nearest entries by fraction.
// - Equal base codes share one region.
// - Base codes 2-7 map to 0x40-0xE0.
// - Entries are 16-bit signed.
module lpag_top (
    input wire logic core_clk, // System clock.
    input wire logic sys_rst, // Synchronous reset, high.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [11:0] adc_result, // Latest converter sample.
    input wire logic adc_valid, // Sample strobe.
    output logic mem_rd_en, // Table read request pulse.
    output logic [7:0] mem_addr, // Table word address.
    input wire logic mem_rd_valid, // Read data strobe.
    input wire logic [15:0] mem_rd_data, // Read data word.
    output logic [15:0] result_data, // Looked-up value.
    output logic result_valid // Result strobe.
);
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic wr_fire, wr_ok;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next, rd_word;
    logic [1:0] rresp_reg, rresp_next;
    logic rd_ok;
    logic [3:0][15:0] cfg_reg, cfg_next;
    logic stream_reg, stream_next, src_reg, src_next;
    logic [1:0] tsel_reg, tsel_next;
    logic [11:0] pwr_reg, pwr_next, adc_last_reg, adc_last_next;
    logic start;
    lpag_pkg::lpag_state_e state_reg, state_next;
    logic [11:0] samp_reg, samp_next;
    logic [1:0] tbl_reg, tbl_next;
    logic [7:0] addr1_reg, addr1_next, mem_addr_reg, mem_addr_next;
    logic [2:0] frac_reg, frac_next;
    logic [15:0] d1_reg, d1_next, res_reg, res_next;
    logic res_valid_reg, res_valid_next, clamp_reg, clamp_next;
    logic signed [15:0] blend;
    lpag_ptr_if ptr();

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] v;
        v = old;
        if (strb[0]) v[7:0] = data[7:0];
        if (strb[1]) v[15:8] = data[15:8];
        return v;
    endfunction

    assign ptr.cfg = cfg_reg[tbl_reg];
    assign ptr.sample = samp_reg;

    lpag_ptr_calc u_calc (
        .p(ptr)
    );

    lpag_interp u_interp (
        .first_val(d1_reg),
        .second_val(mem_rd_data),
        .frac(frac_reg),
        .result(blend)
    );

    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign mem_rd_en = (state_reg == lpag_pkg::ST_FETCH1) ||
                       (state_reg == lpag_pkg::ST_FETCH2);
    assign mem_addr = mem_addr_reg;
    assign result_data = res_reg;
    assign result_valid = res_valid_reg;
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next = w_hold_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_ok ? lpag_pkg::RESP_OK : lpag_pkg::RESP_ERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= lpag_pkg::RESP_OK;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            lpag_pkg::A_CFG0, lpag_pkg::A_CFG1, lpag_pkg::A_CFG2,
            lpag_pkg::A_CFG3: begin
                rd_word = {16'h0, cfg_reg[s_axi_araddr[lpag_pkg::IDX_LO +: 2]]};
            end
            lpag_pkg::A_CTRL: rd_word = {27'h0, src_reg, tsel_reg, 1'b0,
                                         stream_reg};
            lpag_pkg::A_PWR: rd_word = {20'h0, pwr_reg};
            lpag_pkg::A_STAT: rd_word = {30'h0, clamp_reg,
                                         state_reg != lpag_pkg::ST_IDLE};
            lpag_pkg::A_RES: rd_word = {16'h0, res_reg};
            lpag_pkg::A_ADDR: rd_word = {24'h0, addr1_reg};
            default: rd_ok = 1'b0;
        endcase
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rdata_next = rd_word;
            rresp_next = rd_ok ? lpag_pkg::RESP_OK : lpag_pkg::RESP_ERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= lpag_pkg::RESP_OK;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    always_comb begin
        cfg_next = cfg_reg;
        stream_next = stream_reg;
        src_next = src_reg;
        tsel_next = tsel_reg;
        pwr_next = pwr_reg;
        adc_last_next = adc_valid ? adc_result : adc_last_reg;
        start = 1'b0;
        wr_ok = 1'b1;
        case (aw_addr_reg)
            lpag_pkg::A_CFG0, lpag_pkg::A_CFG1, lpag_pkg::A_CFG2,
            lpag_pkg::A_CFG3: begin
                // Locked words answer with an error so software notices.
                wr_ok = stream_reg;
                if (wr_fire && stream_reg)
                    cfg_next[aw_addr_reg[lpag_pkg::IDX_LO +: 2]] = merge16(
                        cfg_reg[aw_addr_reg[lpag_pkg::IDX_LO +: 2]],
                        w_data_reg, w_strb_reg);
            end
            lpag_pkg::A_CTRL: begin
                if (wr_fire && w_strb_reg[0]) begin
                    stream_next = w_data_reg[lpag_pkg::C_STREAM];
                    tsel_next = w_data_reg[lpag_pkg::C_TSEL +: 2];
                    src_next = w_data_reg[lpag_pkg::C_SRC];
                    start = w_data_reg[lpag_pkg::C_START];
                end
            end
            lpag_pkg::A_PWR: begin
                if (wr_fire)
                    pwr_next = 12'(merge16({4'h0, pwr_reg}, w_data_reg,
                                           w_strb_reg));
            end
            lpag_pkg::A_STAT, lpag_pkg::A_RES, lpag_pkg::A_ADDR: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_reg <= {lpag_pkg::NUM_TBL{lpag_pkg::CFG_RST}};
            stream_reg <= 1'b0;
            src_reg <= 1'b0;
            tsel_reg <= 2'h0;
            pwr_reg <= 12'h000;
            adc_last_reg <= 12'h000;
        end else begin
            cfg_reg <= cfg_next;
            stream_reg <= stream_next;
            src_reg <= src_next;
            tsel_reg <= tsel_next;
            pwr_reg <= pwr_next;
            adc_last_reg <= adc_last_next;
        end
    end

    // A start while a lookup runs is dropped; software polls busy first.
    always_comb begin
        state_next = state_reg;
        samp_next = samp_reg;
        tbl_next = tbl_reg;
        addr1_next = addr1_reg;
        mem_addr_next = mem_addr_reg;
        frac_next = frac_reg;
        d1_next = d1_reg;
        res_next = res_reg;
        res_valid_next = 1'b0;
        clamp_next = clamp_reg;
        case (state_reg)
            lpag_pkg::ST_IDLE: begin
                if (start) begin
                    samp_next = src_next ? pwr_reg : adc_last_reg;
                    tbl_next = tsel_next;
                    state_next = lpag_pkg::ST_CALC;
                end
            end
            lpag_pkg::ST_CALC: begin
                addr1_next = ptr.addr;
                mem_addr_next = ptr.addr;
                frac_next = ptr.frac;
                clamp_next = ptr.at_end;
                state_next = lpag_pkg::ST_FETCH1;
            end
            lpag_pkg::ST_FETCH1: state_next = lpag_pkg::ST_WAIT1;
            lpag_pkg::ST_WAIT1: begin
                if (mem_rd_valid) begin
                    d1_next = mem_rd_data;
                    if (frac_reg == 3'h0) begin
                        res_next = mem_rd_data;
                        res_valid_next = 1'b1;
                        state_next = lpag_pkg::ST_IDLE;
                    end else begin
                        mem_addr_next = addr1_reg + 8'h01;
                        state_next = lpag_pkg::ST_FETCH2;
                    end
                end
            end
            lpag_pkg::ST_FETCH2: state_next = lpag_pkg::ST_WAIT2;
            lpag_pkg::ST_WAIT2: begin
                if (mem_rd_valid) begin
                    res_next = blend;
                    res_valid_next = 1'b1;
                    state_next = lpag_pkg::ST_IDLE;
                end
            end
            default: state_next = lpag_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= lpag_pkg::ST_IDLE;
            samp_reg <= 12'h000;
            tbl_reg <= 2'h0;
            addr1_reg <= 8'h00;
            mem_addr_reg <= 8'h00;
            frac_reg <= 3'h0;
            d1_reg <= 16'h0000;
            res_reg <= 16'h0000;
            res_valid_reg <= 1'b0;
            clamp_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            samp_reg <= samp_next;
            tbl_reg <= tbl_next;
            addr1_reg <= addr1_next;
            mem_addr_reg <= mem_addr_next;
            frac_reg <= frac_next;
            d1_reg <= d1_next;
            res_reg <= res_next;
            res_valid_reg <= res_valid_next;
            clamp_reg <= clamp_next;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_cfg_lock;
        !stream_reg |=> $stable(cfg_reg);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("config changed");
    property p_direct;
        state_reg == lpag_pkg::ST_WAIT1 && mem_rd_valid && frac_reg == 3'h0
        |=> result_valid && result_data == $past(mem_rd_data)
            && state_reg == lpag_pkg::ST_IDLE;
    endproperty
    a_direct: assert property (p_direct) else $error("direct read bad");
    property p_second;
        state_reg == lpag_pkg::ST_WAIT1 && mem_rd_valid && frac_reg != 3'h0
        |=> mem_rd_en && mem_addr == addr1_reg + 8'h01 ##1 !mem_rd_en;
    endproperty
    a_second: assert property (p_second) else $error("second read bad");
    property p_blend;
        state_reg == lpag_pkg::ST_WAIT2 && mem_rd_valid
        |=> result_valid && result_data == $past(blend) ##1 !result_valid;
    endproperty
    a_blend: assert property (p_blend) else $error("blend result bad");
    property p_clamp;
        state_reg == lpag_pkg::ST_CALC |-> ptr.index < ptr.len;
    endproperty
    a_clamp: assert property (p_clamp) else $error("index past table");
    property p_end;
        ptr.at_end |-> ptr.frac == 3'h0 && ptr.index == ptr.len - 8'h01;
    endproperty
    a_end: assert property (p_end) else $error("end entry blended");
    property p_addr;
        state_reg == lpag_pkg::ST_CALC |=> mem_rd_en &&
        mem_addr == 8'(($past(ptr.cfg[2:0]) << 5) + $past(ptr.index));
    endproperty
    a_addr: assert property (p_addr) else $error("address form bad");
    property p_shift;
        state_reg == lpag_pkg::ST_CALC && ptr.cfg[15:3] == 13'h0001
        |-> ptr.index == 8'(samp_reg >> 7);
    endproperty
    a_shift: assert property (p_shift) else $error("shift bad");
    property p_source;
        state_reg == lpag_pkg::ST_IDLE && start
        |=> state_reg == lpag_pkg::ST_CALC &&
            samp_reg == ($past(src_next) ? $past(pwr_reg)
                                         : $past(adc_last_reg));
    endproperty
    a_source: assert property (p_source) else $error("source bad");
endmodule
`default_nettype wire

// ==== lpag_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpag_mem_model (
    input wire logic core_clk, // System clock.
    input wire logic sys_rst, // Synchronous reset, high.
    input wire logic mem_rd_en, // Read request pulse.
    input wire logic [7:0] mem_addr, // Word address.
    input wire logic [3:0] lat, // Answer delay in cycles, at least one.
    output logic mem_rd_valid, // Read data strobe.
    output logic [15:0] mem_rd_data // Read data word.
);
    logic [3:0] cnt;
    logic [7:0] adr;
    // Outside the strobe the data bus toggles so a late sample is caught.
    always_ff @(posedge core_clk) begin
        mem_rd_valid <= 1'b0;
        mem_rd_data <= ~mem_rd_data;
        if (sys_rst) begin
            cnt <= 4'h0;
            mem_rd_data <= 16'h0000;
        end else if (mem_rd_en) begin
            cnt <= lat;
            adr <= mem_addr;
        end else if (cnt == 4'h1) begin
            cnt <= 4'h0;
            mem_rd_valid <= 1'b1;
            mem_rd_data <= {4'h0, adr, 4'h0} - 16'h0400;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [15:0] cfg;
        logic [11:0] smp;
        logic [7:0] adr;
        logic [15:0] res;
        logic clp;
    } lpag_row_s;
    logic core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, adc_valid, mem_rd_en;
    logic mem_rd_valid, result_valid;
    logic [7:0] awaddr, araddr, mem_addr;
    logic [31:0] wdata, rdata, q;
    logic [1:0] bresp, rresp, r;
    logic [11:0] adc_result;
    logic [15:0] mem_rd_data, result_data;
    logic [3:0] lat;
    int n_fail, n_checks;
    lpag_row_s rows [8] = '{
        '{16'h200a, 12'h495, 8'h51, 16'h0110, 1'b0},
        '{16'ha2a4, 12'he6a, 8'hc3, 16'h0834, 1'b0},
        '{16'h801b, 12'h100, 8'h60, 16'h0200, 1'b0},
        '{16'h01cf, 12'hfff, 8'hff, 16'h0bf0, 1'b1},
        '{16'hfcf2, 12'h800, 8'hbc, 16'h07c0, 1'b0},
        '{16'h056d, 12'h0a3, 8'ha3, 16'h0638, 1'b0},
        '{16'h0c96, 12'h040, 8'hc8, 16'h0880, 1'b0},
        '{16'h030a, 12'h0f5, 8'h41, 16'h001e, 1'b0}};
    lpag_top uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .adc_result(adc_result), .adc_valid(adc_valid),
        .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
        .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
        .result_data(result_data), .result_valid(result_valid));
    lpag_mem_model mem (.core_clk(core_clk), .sys_rst(sys_rst),
        .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .lat(lat),
        .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Both channels are offered together and each is released once taken.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (wr ? bvalid !== 1'b1 : rvalid !== 1'b1);
        bready <= 1'b0;
        rready <= 1'b0;
        q = rdata;
        r = wr ? bresp : rresp;
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, adc_valid} = 6'h00;
        {awaddr, araddr, wdata, adc_result, lat} = '0;
        n_fail = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        bus(1'b0, lpag_pkg::A_CFG2, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, lpag_pkg::A_CFG0, 32'h1234);
        chk(r, lpag_pkg::RESP_ERR);
        bus(1'b0, lpag_pkg::A_CFG0, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 8'h24, 32'h0);
        chk(r, lpag_pkg::RESP_ERR);
        bus(1'b1, lpag_pkg::A_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            lat <= i[0] ? 4'h5 : 4'h1;
            bus(1'b1, 8'(4 * (i % 4)), {16'h0, rows[i].cfg});
            chk(r, lpag_pkg::RESP_OK);
            bus(1'b0, 8'(4 * (i % 4)), 32'h0);
            chk(q, {16'h0, rows[i].cfg});
            // The unused source carries the inverse so a wrong pick shows.
            bus(1'b1, lpag_pkg::A_PWR,
                {20'h0, i[0] ? rows[i].smp : ~rows[i].smp});
            @(posedge core_clk);
            adc_result <= i[0] ? ~rows[i].smp : rows[i].smp;
            adc_valid <= 1'b1;
            @(posedge core_clk);
            adc_valid <= 1'b0;
            bus(1'b1, lpag_pkg::A_CTRL,
                32'h3 | (32'(i % 4) << 2) | (32'(i[0]) << 4));
            do @(posedge core_clk); while (result_valid !== 1'b1);
            chk(result_data, rows[i].res);
            bus(1'b0, lpag_pkg::A_ADDR, 32'h0);
            chk(q, {24'h0, rows[i].adr});
            bus(1'b0, lpag_pkg::A_STAT, 32'h0);
            chk(q, {30'h0, rows[i].clp, 1'b0});
        end
        // Bare six-bit pointer from the power parameter, clamped at 31.
        bus(1'b1, lpag_pkg::A_CFG0, 32'h004a);
        bus(1'b1, lpag_pkg::A_PWR, 32'hfff);
        bus(1'b1, lpag_pkg::A_CTRL, 32'h13);
        do @(posedge core_clk); while (result_valid !== 1'b1);
        chk(result_data, 32'h01f0);
        bus(1'b0, lpag_pkg::A_ADDR, 32'h0);
        chk(q, 32'h5f);
        // A second reset in mid-run must clear the words and restore the lock.
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        bus(1'b0, lpag_pkg::A_CFG0, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, lpag_pkg::A_CTRL, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, lpag_pkg::A_CFG1, 32'h5);
        chk(r, lpag_pkg::RESP_ERR);
        wrap_up();
    end
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
